// >>> hes_pkg.sv
/*
 * hes_pkg: constants, register indices, field layouts and carrier types for
 * the high-dynamic-range exposure sequencer.
 * Assumes pclk is the sensor master clock, so one unit is 129 pclk periods.
 */
`default_nettype none
package hes_pkg;
   // -------------------------------------------------------------------
   // register indices (byte address = index * 4)
   // -------------------------------------------------------------------
   localparam int         ADDR_W       = 12;
   localparam int         IDX_LSB      = 2;
   localparam int         IDX_W        = 8;
   localparam logic [7:0] IDX_EXP_CTRL = 8'h29;
   localparam logic [7:0] IDX_BASE     = 8'h2a;
   localparam logic [7:0] IDX_STEP     = 8'h2d;
   localparam logic [7:0] IDX_KNEE1    = 8'h30;
   localparam logic [7:0] IDX_KNEE2    = 8'h33;
   localparam logic [7:0] IDX_SLOPES   = 8'h36;
   localparam logic [7:0] IDX_SEQ      = 8'h37;
   localparam logic [7:0] IDX_HDR      = 8'h3c;
   localparam logic [7:0] IDX_CMD      = 8'h3d;
   localparam logic [7:0] IDX_STAT     = 8'h3e;
   localparam logic [7:0] IDX_FOT      = 8'h49;
   localparam logic [7:0] IDX_LVL2     = 8'h59;
   localparam logic [7:0] IDX_LVL3     = 8'h5a;
   // -------------------------------------------------------------------
   // reset values and field positions
   // -------------------------------------------------------------------
   localparam logic [23:0] BASE_RST   = 24'h000440;
   localparam logic [23:0] STEP_RST   = 24'h000000;
   localparam logic [23:0] KNEE_RST   = 24'h000001;
   localparam logic [1:0]  SLOPES_RST = 2'h1;
   localparam logic [7:0]  SEQ_RST    = 8'h01;
   localparam logic [6:0]  LVL_RST    = 7'h60;
   localparam logic [7:0]  FOT_RST    = 8'h0a;
   localparam int          EXT_BIT    = 0;
   localparam int          DUAL_BIT   = 1;
   localparam int          PWL_BIT    = 0;
   localparam int          MF_BIT     = 1;
   localparam int          START_BIT  = 0;
   localparam int          LVL_EN_BIT = 6;
   // -------------------------------------------------------------------
   // timing: one unit is 129 clocks, overhead is 0.43 units per fot step
   // -------------------------------------------------------------------
   localparam int          CW        = 40;
   localparam logic [31:0] UNIT_CLKS = 32'h00000081;
   localparam logic [31:0] OVH_NUM   = 32'h000015ab;
   localparam logic [31:0] OVH_DEN   = 32'h00000064;

   typedef struct packed {
      logic [23:0] base;
      logic [23:0] step;
      logic [23:0] knee1;
      logic [23:0] knee2;
      logic [1:0]  slopes;
      logic [7:0]  seq;
      logic [6:0]  lvl2;
      logic [6:0]  lvl3;
      logic [7:0]  fot;
   } hes_cfg_t;

   typedef struct packed {
      logic       apply;
      logic [5:0] code;
   } hes_clamp_t;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b001,
      S_EXPOSE = 3'b010,
      S_TAIL   = 3'b100
   } hes_state_t;

   // overhead in clocks, rounded to nearest: fot * 55.47
   function automatic logic [CW-1:0] ovh_cycles(input logic [7:0] fot);
      logic [31:0] t;
      t = ({24'h0, fot} * OVH_NUM + (OVH_DEN >> 1)) / OVH_DEN;
      return {8'h0, t};
   endfunction

   function automatic logic [CW-1:0] unit_cycles(input logic [31:0] u);
      logic [63:0] t;
      t = {32'h0, u} * {32'h0, UNIT_CLKS};
      return t[CW-1:0];
   endfunction
endpackage
`default_nettype wire

// >>> hes_exposure_sequencer.sv
/*
 * hes_exposure_sequencer: exposure timing, piecewise-linear clamp phases and
 * multi-frame sequencing behind an APB register file.
 * Assumes pclk is the master clock; trigger pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module hes_exposure_sequencer (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic [hes_pkg::ADDR_W-1:0] paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       frame_request,
   input  wire logic                       exposure_trigger_a,
   input  wire logic                       exposure_trigger_b,
   output logic                            exposing,
   output hes_pkg::hes_clamp_t             clamp,
   output logic                            frame_done,
   output logic      [7:0]                 frame_index,
   output logic                            interleave_en
);
   import hes_pkg::*;

   // ---------------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------------
   hes_cfg_t         cfg_q;
   logic [1:0]       ctrl_q;
   logic [1:0]       hdr_q;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;
   logic [IDX_W-1:0] idx;
   logic             mapped;
   logic             wr;
   logic             start_cmd;

   function automatic logic decode(input logic [ADDR_W-1:0] a);
      logic [IDX_W-1:0] i;
      i = a[IDX_LSB +: IDX_W];
      return (a[1:0] == 2'h0) && (a[ADDR_W-1:IDX_LSB+IDX_W] == '0) &&
             (i == IDX_EXP_CTRL || i == IDX_BASE || i == IDX_STEP ||
              i == IDX_KNEE1 || i == IDX_KNEE2 || i == IDX_SLOPES ||
              i == IDX_SEQ || i == IDX_HDR || i == IDX_CMD ||
              i == IDX_STAT || i == IDX_FOT || i == IDX_LVL2 ||
              i == IDX_LVL3);
   endfunction

   assign idx       = paddr[IDX_LSB +: IDX_W];
   assign mapped    = decode(paddr);
   assign wr        = psel & penable & pwrite & pready_q & mapped;
   assign start_cmd = wr & (idx == IDX_CMD) & pwdata[START_BIT];

   // zero-wait slave: the answer is prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel & ~penable;
         pslverr_q <= psel & ~penable & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q.base   <= BASE_RST;
         cfg_q.step   <= STEP_RST;
         cfg_q.knee1  <= KNEE_RST;
         cfg_q.knee2  <= KNEE_RST;
         cfg_q.slopes <= SLOPES_RST;
         cfg_q.seq    <= SEQ_RST;
         cfg_q.lvl2   <= LVL_RST;
         cfg_q.lvl3   <= LVL_RST;
         cfg_q.fot    <= FOT_RST;
         ctrl_q       <= 2'h0;
         hdr_q        <= 2'h0;
      end else if (wr) begin
         unique case (idx)
            IDX_EXP_CTRL: ctrl_q       <= pwdata[1:0];
            IDX_BASE:     cfg_q.base   <= pwdata[23:0];
            IDX_STEP:     cfg_q.step   <= pwdata[23:0];
            IDX_KNEE1:    cfg_q.knee1  <= pwdata[23:0];
            IDX_KNEE2:    cfg_q.knee2  <= pwdata[23:0];
            IDX_SLOPES:   cfg_q.slopes <= pwdata[1:0];
            IDX_SEQ:      cfg_q.seq    <= pwdata[7:0];
            IDX_HDR:      hdr_q        <= pwdata[1:0];
            IDX_FOT:      cfg_q.fot    <= pwdata[7:0];
            IDX_LVL2:     cfg_q.lvl2   <= pwdata[6:0];
            IDX_LVL3:     cfg_q.lvl3   <= pwdata[6:0];
            default:      ;
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------------------------------
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] sync3_q;
   logic       fr_rise;
   logic       ta_rise;
   logic       tb_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
      end else begin
         sync1_q <= {exposure_trigger_b, exposure_trigger_a, frame_request};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign fr_rise = sync2_q[0] & ~sync3_q[0];
   assign ta_rise = sync2_q[1] & ~sync3_q[1];
   assign tb_rise = sync2_q[2] & ~sync3_q[2];

   // ---------------------------------------------------------------------
   // exposure sequencer
   // ---------------------------------------------------------------------
   hes_state_t     state_q;
   hes_cfg_t       cur_q;
   logic           ext_q;
   logic           pwl_q;
   logic           mf_q;
   logic [31:0]    units_q;
   logic [CW-1:0]  elapsed_q;
   logic [CW-1:0]  total_q;
   logic [CW-1:0]  k1_q;
   logic [CW-1:0]  k2_q;
   logic [1:0]     ext_phase_q;
   logic [7:0]     index_q;
   logic           done_q;
   logic           exposing_q;
   logic           ext_start;
   logic           int_start;
   logic           last_clk;
   logic [31:0]    next_units;
   logic [CW-1:0]  ovh;

   assign ext_start  = ctrl_q[EXT_BIT] & ta_rise;
   assign int_start  = ~ctrl_q[EXT_BIT] & (start_cmd | fr_rise);
   assign last_clk   = (elapsed_q + 1'b1) >= total_q;
   assign next_units = units_q + {8'h0, cur_q.step};
   assign ovh        = ovh_cycles(cur_q.fot);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= S_IDLE;
         cur_q       <= '0;
         ext_q       <= 1'b0;
         pwl_q       <= 1'b0;
         mf_q        <= 1'b0;
         units_q     <= 32'h0;
         elapsed_q   <= '0;
         total_q     <= '0;
         k1_q        <= '0;
         k2_q        <= '0;
         ext_phase_q <= 2'h0;
         index_q     <= 8'h0;
         done_q      <= 1'b0;
         exposing_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               if (int_start | ext_start) begin
                  // settings are frozen for the whole sequence
                  cur_q       <= cfg_q;
                  ext_q       <= ctrl_q[EXT_BIT];
                  pwl_q       <= hdr_q[PWL_BIT] & ~ctrl_q[DUAL_BIT];
                  mf_q        <= hdr_q[MF_BIT] & ~ctrl_q[EXT_BIT];
                  units_q     <= {8'h0, cfg_q.base};
                  elapsed_q   <= '0;
                  total_q     <= ovh_cycles(cfg_q.fot) +
                                 unit_cycles({8'h0, cfg_q.base});
                  k1_q        <= ovh_cycles(cfg_q.fot) +
                                 unit_cycles({8'h0, cfg_q.knee1});
                  k2_q        <= ovh_cycles(cfg_q.fot) +
                                 unit_cycles({8'h0, cfg_q.knee2});
                  ext_phase_q <= 2'h0;
                  index_q     <= 8'h01;
                  exposing_q  <= 1'b1;
                  state_q     <= S_EXPOSE;
               end
            end
            S_EXPOSE: begin
               elapsed_q <= elapsed_q + 1'b1;
               if (ext_q) begin
                  // trigger b advances the clamp phase, frame request ends
                  if (tb_rise && ext_phase_q != 2'h2)
                     ext_phase_q <= ext_phase_q + 2'h1;
                  if (fr_rise) begin
                     elapsed_q <= '0;
                     total_q   <= ovh;
                     state_q   <= S_TAIL;
                  end
               end else if (last_clk) begin
                  done_q <= 1'b1;
                  if (mf_q && index_q < cur_q.seq) begin
                     // next frame starts at once with the exposure grown by the step
                     index_q   <= index_q + 8'h01;
                     units_q   <= next_units;
                     elapsed_q <= '0;
                     total_q   <= ovh + unit_cycles(next_units);
                  end else begin
                     exposing_q <= 1'b0;
                     state_q    <= S_IDLE;
                  end
               end
            end
            S_TAIL: begin
               elapsed_q <= elapsed_q + 1'b1;
               if (last_clk) begin
                  done_q     <= 1'b1;
                  exposing_q <= 1'b0;
                  state_q    <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // clamp phases: knee one first, then knee two, then free integration
   // ---------------------------------------------------------------------
   logic [1:0] phase;
   logic [1:0] max_phase;
   hes_clamp_t clamp_d;
   hes_clamp_t clamp_q;

   always_comb begin
      phase = 2'h0;
      if (state_q == S_EXPOSE) begin
         if (ext_q)
            phase = (ext_phase_q == 2'h2) ? 2'h0 : ext_phase_q + 2'h1;
         else if (elapsed_q < k1_q)
            phase = 2'h1;
         else if (elapsed_q < k1_q + k2_q)
            phase = 2'h2;
      end
      // slope count 0 is illegal and acts as a single slope
      max_phase = (cur_q.slopes == 2'h0) ? 2'h0 : cur_q.slopes - 2'h1;
      clamp_d = '0;
      if (pwl_q && phase != 2'h0 && phase <= max_phase) begin
         if (phase == 2'h1 && cur_q.lvl2[LVL_EN_BIT])
            clamp_d = '{apply: 1'b1, code: cur_q.lvl2[5:0]};
         else if (phase == 2'h2 && cur_q.lvl3[LVL_EN_BIT])
            clamp_d = '{apply: 1'b1, code: cur_q.lvl3[5:0]};
      end
   end

   // the pixel array clamps only pixels above the level; others untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clamp_q <= '0;
      else
         clamp_q <= clamp_d;
   end

   // ---------------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         unique case (idx)
            IDX_EXP_CTRL: prdata_q <= {30'h0, ctrl_q};
            IDX_BASE:     prdata_q <= {8'h0, cfg_q.base};
            IDX_STEP:     prdata_q <= {8'h0, cfg_q.step};
            IDX_KNEE1:    prdata_q <= {8'h0, cfg_q.knee1};
            IDX_KNEE2:    prdata_q <= {8'h0, cfg_q.knee2};
            IDX_SLOPES:   prdata_q <= {30'h0, cfg_q.slopes};
            IDX_SEQ:      prdata_q <= {24'h0, cfg_q.seq};
            IDX_HDR:      prdata_q <= {30'h0, hdr_q};
            IDX_STAT:     prdata_q <= {20'h0, index_q, 1'b0, state_q};
            IDX_FOT:      prdata_q <= {24'h0, cfg_q.fot};
            IDX_LVL2:     prdata_q <= {25'h0, cfg_q.lvl2};
            IDX_LVL3:     prdata_q <= {25'h0, cfg_q.lvl3};
            default:      prdata_q <= 32'h0;
         endcase
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign exposing      = exposing_q;
   assign clamp         = clamp_q;
   assign frame_done    = done_q;
   assign frame_index   = index_q;
   assign interleave_en = ctrl_q[DUAL_BIT];

   // ---------------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------------
   property p_slope_one;
      @(posedge pclk) disable iff (!presetn)
      (state_q == S_EXPOSE && cur_q.slopes <= 2'h1) |=> !clamp.apply;
   endproperty
   a_slope_one: assert property (p_slope_one)
      else $error("clamp applied with a single slope");

   property p_lvl2_off;
      @(posedge pclk) disable iff (!presetn)
      (phase == 2'h1 && !cur_q.lvl2[LVL_EN_BIT]) |=> !clamp.apply;
   endproperty
   a_lvl2_off: assert property (p_lvl2_off)
      else $error("disabled second level applied");

   property p_lvl3_code;
      @(posedge pclk) disable iff (!presetn)
      (pwl_q && phase == 2'h2 && cur_q.slopes == 2'h3 &&
       cur_q.lvl3[LVL_EN_BIT]) |=> clamp.apply &&
       clamp.code == $past(cur_q.lvl3[5:0]);
   endproperty
   a_lvl3_code: assert property (p_lvl3_code)
      else $error("third level not applied in phase two");

   property p_idle_free;
      @(posedge pclk) disable iff (!presetn)
      (state_q != S_EXPOSE) |=> !clamp.apply;
   endproperty
   a_idle_free: assert property (p_idle_free)
      else $error("clamp outside exposure");

   property p_frozen;
      @(posedge pclk) disable iff (!presetn)
      (state_q != S_IDLE) |=> (state_q == S_IDLE) || $stable(cur_q);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("snapshot changed during exposure");

   property p_step;
      @(posedge pclk) disable iff (!presetn)
      (done_q == 1'b0 && state_q == S_EXPOSE && !ext_q && last_clk &&
       mf_q && index_q < cur_q.seq) |=>
       units_q == $past(units_q) + {8'h0, cur_q.step} &&
       index_q == $past(index_q) + 8'h01;
   endproperty
   a_step: assert property (p_step)
      else $error("frame exposure did not grow by the step");

   property p_seq_end;
      @(posedge pclk) disable iff (!presetn)
      (state_q == S_EXPOSE && !ext_q && last_clk &&
       (!mf_q || index_q >= cur_q.seq)) |=>
       state_q == S_IDLE && frame_done && !exposing;
   endproperty
   a_seq_end: assert property (p_seq_end)
      else $error("sequence did not end after last frame");

   property p_int_len;
      @(posedge pclk) disable iff (!presetn)
      (state_q == S_IDLE && int_start && cfg_q.fot == 8'h0 &&
       cfg_q.base == 24'h1 && !hdr_q[MF_BIT]) |=>
       exposing [*8] ##[120:122] (frame_done && !exposing);
   endproperty
   a_int_len: assert property (p_int_len)
      else $error("unit exposure is not 129 clocks");

   property p_ext_end;
      @(posedge pclk) disable iff (!presetn)
      (state_q == S_EXPOSE && ext_q && fr_rise) |=>
       state_q == S_TAIL && exposing;
   endproperty
   a_ext_end: assert property (p_ext_end)
      else $error("frame request did not end external exposure");
endmodule // hes_exposure_sequencer
`default_nettype wire

// >>> hes_ctrl_model.sv
/* hes_ctrl_model: camera controller side of the three exposure pins.
   Assumes pulse() is called just after a rising pclk edge. */
`timescale 1ns/1ps
`default_nettype none
module hes_ctrl_model (
   input  wire logic pclk,
   output var logic  frame_request,
   output var logic  exposure_trigger_a,
   output var logic  exposure_trigger_b
);
   logic [2:0] pins_q = 3'h0;
   assign exposure_trigger_a = pins_q[0];
   assign exposure_trigger_b = pins_q[1];
   assign frame_request      = pins_q[2];
   // 0 trigger a, 1 trigger b, 2 frame request; three clocks wide so the
   // two-flop synchroniser cannot miss it, rises spaced by gap plus four
   task automatic pulse(input int pin);
      @(posedge pclk);
      pins_q[pin] <= 1'b1;
      repeat (3) @(posedge pclk);
      pins_q[pin] <= 1'b0;
   endtask
endmodule // hes_ctrl_model
`default_nettype wire

// >>> hes_exposure_sequencer_test.sv
/* hes_exposure_sequencer_test: register, frame and clamp checks.
   Assumes zero-wait APB and the pin model hes_ctrl_model. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: got %0h exp %0h", $time, a, b); end end
module hes_exposure_sequencer_test;
   import hes_pkg::*;
   typedef struct {int len; int idx; int c2; int c3;} hes_note_t;
   logic              pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic              pwrite = 0, pready, pslverr, rq, ta, tb, er;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd, w;
   logic              exposing, frame_done, interleave_en;
   hes_clamp_t        clamp;
   logic [7:0]        frame_index;
   int                num_errors = 0, n_tests = 0, seed = 32'habdc1b0a;
   int                f, b, s, o, g, len = 0, k2 = 0, k3 = 0;
   hes_note_t         notes[$];
   hes_note_t         n;
   logic [7:0]  ri[9] = '{IDX_BASE, IDX_STEP, IDX_KNEE1, IDX_KNEE2,
      IDX_SLOPES, IDX_SEQ, IDX_LVL2, IDX_LVL3, IDX_FOT};
   logic [31:0] rv[9] = '{32'h440, 32'h0, 32'h1, 32'h1, 32'h1, 32'h1,
      32'h60, 32'h60, 32'h0a};
   logic [31:0] rm[9] = '{32'hffffff, 32'hffffff, 32'hffffff, 32'hffffff,
      32'h3, 32'hff, 32'h7f, 32'h7f, 32'hff};
   int sl[4] = '{3, 2, 3, 3};
   int l2[4] = '{'h45, 'h45, 'h05, 'h45};
   int ct[4] = '{0, 0, 0, 2};

   hes_exposure_sequencer i_dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_request(rq), .exposure_trigger_a(ta), .exposure_trigger_b(tb),
      .exposing(exposing), .clamp(clamp), .frame_done(frame_done),
      .frame_index(frame_index), .interleave_en(interleave_en));
   hes_ctrl_model i_ctl (.pclk(pclk), .frame_request(rq),
      .exposure_trigger_a(ta), .exposure_trigger_b(tb));

   initial forever #4 pclk = ~pclk;

   task automatic conclude();
      $display("errors %0d comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // bus master and frame notes
   // ---------------------------------------------------------------
   task automatic apb(input logic wr_en, input logic [7:0] idx,
                      input logic [31:0] wd);
      int t;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr_en; paddr <= {2'b0, idx, 2'b0};
      pwdata <= wd;
      @(posedge pclk) penable <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
      if (t == 50) begin num_errors++; conclude(); end
   endtask

   task automatic wr(input logic [7:0] idx, input int d);
      apb(1'b1, idx, d);
   endtask

   task automatic note(int l, int nf, int st, int c2, int c3);
      for (int i = 0; i < nf; i++)
         // at each done pulse but the last, the index already names the next frame
         notes.push_back('{(l < 0) ? -1 : l + i * st,
            (i + 1 < nf) ? i + 2 : i + 1, c2, c3});
   endtask

   task automatic drain();
      int t;
      for (t = 0; t < 20000 && (notes.size() > 0 || exposing !== 1'b0); t++)
         @(posedge pclk);
      if (t == 20000) begin num_errors++; conclude(); end
   endtask

   // ---------------------------------------------------------------
   // result watcher: one note per frame_done pulse
   // ---------------------------------------------------------------
   always @(negedge pclk) begin
      if (frame_done === 1'b1) begin
         if (notes.size() == 0) `CHK(1'b1, 1'b0)
         else begin
            n = notes.pop_front();
            if (n.len >= 0) `CHK(len, n.len)
            `CHK(frame_index, n.idx[7:0])
            `CHK(k2, n.c2)
            `CHK(k3, n.c3)
         end
         // back-to-back frames: this cycle already belongs to the next one
         len = (exposing === 1'b1); k2 = 0; k3 = 0;
      end else begin
         len += (exposing === 1'b1);
         k2 += (clamp.apply === 1'b1 && clamp.code === 6'h05);
         k3 += (clamp.apply === 1'b1 && clamp.code === 6'h0a);
      end
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, ri[i], 32'h0);
         `CHK(rd, rv[i])
         w = $random(seed) & rm[i];
         wr(ri[i], w);
         apb(1'b0, ri[i], 32'h0);
         `CHK(rd, w)
      end
      apb(1'b0, 8'h00, 32'h0);
      `CHK(er, 1'b1)
      // one-unit frame started from the frame request pin
      wr(IDX_FOT, 0); wr(IDX_BASE, 1); note(129, 1, 0, 0, 0);
      i_ctl.pulse(2); drain();
      f = $random(seed) & 3;
      b = 4 + ($random(seed) & 3);
      s = 1 + ($random(seed) & 1);
      o = (f * 5547 + 50) / 100;
      wr(IDX_FOT, f); wr(IDX_BASE, b); wr(IDX_HDR, 0); wr(IDX_EXP_CTRL, 0);
      note(o + 129 * b, 1, 0, 0, 0);
      wr(IDX_CMD, 1); wr(IDX_BASE, b + 3); drain();
      note(o + 129 * (b + 3), 1, 0, 0, 0);
      wr(IDX_CMD, 1); drain();
      wr(IDX_STEP, s); wr(IDX_SEQ, 3); wr(IDX_HDR, 2);
      note(o + 129 * (b + 3), 3, 129 * s, 0, 0);
      wr(IDX_CMD, 1); drain();
      wr(IDX_HDR, 1); wr(IDX_KNEE1, 1); wr(IDX_KNEE2, 2); wr(IDX_LVL3, 'h4a);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_SLOPES, sl[i]); wr(IDX_LVL2, l2[i]); wr(IDX_EXP_CTRL, ct[i]);
         note(o + 129 * (b + 3), 1, 0, (l2[i] == 'h45 && ct[i] == 0) ?
            o + 129 : 0, (sl[i] == 3 && ct[i] == 0) ? o + 258 : 0);
         wr(IDX_CMD, 1); drain();
      end
      `CHK(interleave_en, 1'b1)
      wr(IDX_HDR, 3); wr(IDX_EXP_CTRL, 1);
      g = 30 + ($random(seed) & 15);
      note(-1, 1, 0, g + 4, 44);
      i_ctl.pulse(0); repeat (g) @(posedge pclk);
      i_ctl.pulse(1); repeat (40) @(posedge pclk);
      i_ctl.pulse(1); repeat (20) @(posedge pclk);
      i_ctl.pulse(2); drain();
      conclude();
   end
endmodule // hes_exposure_sequencer_test
`default_nettype wire
